/* shared/pcxs_pkg.sv */
// Functional notes
// - read-only 3-bit read-size field sits in status bits 28 to 26
// - codes 0..7 mean 1 KB doubling up to 128 KB
// - field value chosen by loaded map-select and large-read configuration bits and by byte count
// - map-select 0: byte count codes 0 and 1 give field code 0
// - map-select 0: byte count 2 gives code 1, byte count 3 gives 2
// - map-select 1, large-read 0: field code 1 regardless of byte count
// - map-select 1, large-read 1: field code 2 regardless of byte count
// - flag sets on received split completion error message
// - error flag readable, cleared only by writing one; zero leaves it
// - error flag lives at status bit 29
package pcxs_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [31:0] PCXS_STATUS_OFS = 32'h0000_0000;
   localparam logic [31:0] PCXS_MASK_OFS   = 32'h0000_0004;

   // ==========================================================
   // field positions
   localparam int PCXS_ERR_BIT  = 29;
   localparam int PCXS_SIZE_LSB = 26;
   localparam int PCXS_SIZE_MSB = 28;

   // ==========================================================
   // read-size codes (1 KB shifted left by the code)
   localparam logic [2:0] PCXS_SIZE_1K = 3'h0;
   localparam logic [2:0] PCXS_SIZE_2K = 3'h1;
   localparam logic [2:0] PCXS_SIZE_4K = 3'h2;

   // byte count codes from the command register
   localparam logic [1:0] PCXS_BC_512 = 2'h0;
   localparam logic [1:0] PCXS_BC_1K  = 2'h1;
   localparam logic [1:0] PCXS_BC_2K  = 2'h2;
   localparam logic [1:0] PCXS_BC_4K  = 2'h3;

   // ==========================================================
   // reset values and responses
   localparam logic       PCXS_ERR_RST  = 1'b0;
   localparam logic       PCXS_MASK_RST = 1'b0;
   localparam logic [1:0] PCXS_RESP_OK  = 2'h0;
   localparam logic [1:0] PCXS_RESP_ERR = 2'h2;

   // register selector from the address decoder
   typedef enum logic [1:0] {PCXS_SEL_STATUS,
                             PCXS_SEL_MASK,
                             PCXS_SEL_NONE} pcxs_sel_t;

   // configuration that steers the read-size field
   typedef struct packed {
      logic       read_size_map_select; // loaded from eeprom word
      logic       large_read;           // loaded from eeprom word
      logic [1:0] byte_count;           // max memory read byte count
   } pcxs_cfg_t;

endpackage

/* logic/pcxs_status.sv */
`timescale 1ns/10ps
module pcxs_status
   import pcxs_pkg::*;
(
   input  wire logic        sys_clk,       // 125 MHz clock
   input  wire logic        resetn,        // async reset, active low
   input  wire pcxs_cfg_t   cfg,           // eeprom bits and byte count
   input  wire logic        scerr_msg,     // split compl error message seen
   input  wire logic [31:0] s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [31:0] s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready,  // read data ready
   output logic [2:0]       read_size,     // current read-size code
   output logic             irq            // level interrupt
);

   // ==========================================================
   // helpers
   // address decode shared by the read and write paths
   function automatic pcxs_sel_t pcxs_decode(input logic [31:0] a);
      pcxs_sel_t s;
      s = PCXS_SEL_NONE;
      if (a == PCXS_STATUS_OFS) begin
         s = PCXS_SEL_STATUS;
      end else if (a == PCXS_MASK_OFS) begin
         s = PCXS_SEL_MASK;
      end
      return s;
   endfunction

   // ==========================================================
   // state
   logic        aw_held_reg, aw_held_next;
   logic [31:0] awaddr_reg, awaddr_next;
   logic        w_held_reg, w_held_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0]  wstrb_reg, wstrb_next;
   logic        awready_reg, awready_next;
   logic        wready_reg, wready_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        arready_reg, arready_next;
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic        err_reg, err_next;
   logic        mask_reg, mask_next;
   logic        irq_reg, irq_next;
   logic [2:0]  size_reg, size_next;
   logic        do_write;
   logic        err_clr;
   logic        ar_take;

   // ==========================================================
   // read-size field, pure function of the inputs so a host write
   // can never disturb it
   always_comb begin
      size_next = PCXS_SIZE_1K;
      if (cfg.read_size_map_select) begin
         if (cfg.large_read) begin
            size_next = PCXS_SIZE_4K;
         end else begin
            size_next = PCXS_SIZE_2K;
         end
      end else begin
         unique case (cfg.byte_count)
            PCXS_BC_512: size_next = PCXS_SIZE_1K;
            PCXS_BC_1K:  size_next = PCXS_SIZE_1K;
            PCXS_BC_2K:  size_next = PCXS_SIZE_2K;
            PCXS_BC_4K:  size_next = PCXS_SIZE_4K;
         endcase
      end
   end

   // ==========================================================
   // write channel: address and data taken in either order,
   // the write happens once both are held
   always_comb begin
      do_write     = aw_held_reg & w_held_reg & ~bvalid_reg;
      aw_held_next = aw_held_reg;
      awaddr_next  = awaddr_reg;
      w_held_next  = w_held_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bresp_next   = bresp_reg;
      mask_next    = mask_reg;
      err_clr      = 1'b0;
      if (s_axi_awvalid & awready_reg) begin
         aw_held_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (s_axi_wvalid & wready_reg) begin
         w_held_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
      end
      if (do_write) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bresp_next   = PCXS_RESP_OK;
         unique case (pcxs_decode(awaddr_reg))
            PCXS_SEL_STATUS: begin
               // size bits are not stored, so writes there vanish
               err_clr = wstrb_reg[3] & wdata_reg[PCXS_ERR_BIT];
            end
            PCXS_SEL_MASK: begin
               if (wstrb_reg[3]) begin
                  mask_next = wdata_reg[PCXS_ERR_BIT];
               end
            end
            PCXS_SEL_NONE: bresp_next = PCXS_RESP_ERR;
         endcase
      end
      bvalid_next  = do_write | (bvalid_reg & ~s_axi_bready);
      awready_next = ~aw_held_next & ~bvalid_next;
      wready_next  = ~w_held_next & ~bvalid_next;
   end

   // ==========================================================
   // error flag and interrupt; a new event beats a same-cycle clear
   always_comb begin
      err_next = scerr_msg | (err_reg & ~err_clr);
      irq_next = err_next & mask_next;
   end

   // ==========================================================
   // read channel, one read at a time, data captured at the take
   always_comb begin
      ar_take    = s_axi_arvalid & arready_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (ar_take) begin
         rdata_next = 32'h0000_0000;
         rresp_next = PCXS_RESP_OK;
         unique case (pcxs_decode(s_axi_araddr))
            PCXS_SEL_STATUS: begin
               rdata_next[PCXS_ERR_BIT] = err_reg;
               rdata_next[PCXS_SIZE_MSB:PCXS_SIZE_LSB] = size_next;
            end
            PCXS_SEL_MASK:   rdata_next[PCXS_ERR_BIT] = mask_reg;
            PCXS_SEL_NONE:   rresp_next = PCXS_RESP_ERR;
         endcase
      end
      rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready);
      arready_next = ~rvalid_next;
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= 32'h0000_0000;
         w_held_reg  <= 1'b0;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= PCXS_RESP_OK;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= PCXS_RESP_OK;
         err_reg     <= PCXS_ERR_RST;
         mask_reg    <= PCXS_MASK_RST;
         irq_reg     <= 1'b0;
         size_reg    <= PCXS_SIZE_1K;
      end else begin
         aw_held_reg <= aw_held_next;
         awaddr_reg  <= awaddr_next;
         w_held_reg  <= w_held_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
         err_reg     <= err_next;
         mask_reg    <= mask_next;
         irq_reg     <= irq_next;
         size_reg    <= size_next;
      end
   end

   // outputs straight from flops
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign read_size     = size_reg;
   assign irq           = irq_reg;

   // ==========================================================
   // checks
   a_map_low_counts: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (!cfg.read_size_map_select && cfg.byte_count <= PCXS_BC_1K)
      |=> read_size == PCXS_SIZE_1K)
      else $error("byte count 0 or 1 must give 1 KB code");

   a_map_high_counts: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (!cfg.read_size_map_select && cfg.byte_count >= PCXS_BC_2K)
      |=> read_size == $past(cfg.byte_count) - 3'h1)
      else $error("byte count 2 or 3 must give code 1 or 2");

   a_fixed_small: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (cfg.read_size_map_select && !cfg.large_read)
      |=> read_size == PCXS_SIZE_2K)
      else $error("fixed mapping without large read must give 2 KB");

   a_fixed_large: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (cfg.read_size_map_select && cfg.large_read)
      |=> read_size == PCXS_SIZE_4K)
      else $error("fixed mapping with large read must give 4 KB");

   a_err_sets: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      scerr_msg |=> err_reg)
      else $error("error message did not set the flag");

   a_err_holds: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (err_reg && !(do_write && awaddr_reg == PCXS_STATUS_OFS
                    && wstrb_reg[3] && wdata_reg[PCXS_ERR_BIT]))
      |=> err_reg)
      else $error("error flag dropped without a one written");

   a_err_clears: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (do_write && awaddr_reg == PCXS_STATUS_OFS && wstrb_reg[3]
       && wdata_reg[PCXS_ERR_BIT] && !scerr_msg)
      |=> !err_reg ##0 s_axi_bvalid)
      else $error("writing one did not clear the flag");

   a_status_read: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (ar_take && s_axi_araddr == PCXS_STATUS_OFS)
      |=> s_axi_rvalid && s_axi_rdata[PCXS_ERR_BIT] == $past(err_reg)
          && s_axi_rdata[PCXS_SIZE_MSB:PCXS_SIZE_LSB] == read_size
          && s_axi_rdata[31:30] == 2'h0 && s_axi_rdata[25:0] == 26'h0)
      else $error("status read shows wrong flag or size");

   a_size_ignores_wr: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (do_write && $stable(cfg)) |=> $stable(read_size))
      else $error("host write disturbed the read-size field");

   a_irq_level: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      ##1 irq == (err_reg && mask_reg))
      else $error("interrupt does not follow flag and mask");

   // an event in the same cycle as a clearing write must not be lost
   a_set_wins: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (scerr_msg && err_clr) |=> err_reg && s_axi_bvalid)
      else $error("event lost to a clear in the same cycle");

   a_unmapped_wr: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (do_write && awaddr_reg != PCXS_STATUS_OFS
       && awaddr_reg != PCXS_MASK_OFS)
      |=> s_axi_bvalid && s_axi_bresp == PCXS_RESP_ERR && $stable(mask_reg))
      else $error("unmapped write must give error and change nothing");

   a_mask_read: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (ar_take && s_axi_araddr == PCXS_MASK_OFS)
      |=> s_axi_rdata == {2'h0, $past(mask_reg), 29'h0}
          && s_axi_rresp == PCXS_RESP_OK)
      else $error("mask read shows wrong bit or response");

   a_unmapped_rd: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (ar_take && s_axi_araddr != PCXS_STATUS_OFS
       && s_axi_araddr != PCXS_MASK_OFS)
      |=> s_axi_rresp == PCXS_RESP_ERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read must give error and zero data");

endmodule

/* sim/pcxs_far_model.sv */
`timescale 1ns/10ps
// ==========================================================
// far side: stands in for the loader, command register and split engine
module pcxs_far_model
   import pcxs_pkg::*;
(
   input  wire logic      sys_clk,  // bus clock
   input  wire logic      resetn,   // async reset, active low
   input  wire pcxs_cfg_t cfg_req,  // configuration the bench wants
   input  wire logic      err_req,  // bench asks for an error message
   output pcxs_cfg_t      cfg,      // configuration to the block
   output logic           scerr_msg // split completion error seen
);
   // registered so that every change lands just after an edge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cfg       <= '0;
         scerr_msg <= 1'b0;
      end else begin
         cfg       <= cfg_req;
         scerr_msg <= err_req;
      end
   end
endmodule

/* sim/pcxs_status_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
   tests_run++; \
   if ((gt) !== (ex)) begin \
      $display("BAD %s exp %h got %h", nm, ex, gt); \
      error_cnt++; \
   end
module pcxs_status_tb;
   import pcxs_pkg::*;
   logic        sys_clk = 1'b0, resetn = 1'b0, err_req = 1'b0, irq;
   logic        scerr_msg;
   pcxs_cfg_t   cfg, cfg_req = '0, c;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rnd = 32'h78b0;
   logic [3:0]  wstrb = '0, k;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, eb;
   logic [2:0]  read_size, sz;
   logic [33:0] er;
   logic [1:0]  wq[$];
   logic [33:0] rq[$];
   int          error_cnt = 0, tests_run = 0;
   localparam logic [31:0] ERRB = 32'h2000_0000;

   always #4 sys_clk = ~sys_clk;

   pcxs_far_model far (.sys_clk(sys_clk), .resetn(resetn), .cfg_req(cfg_req),
      .err_req(err_req), .cfg(cfg), .scerr_msg(scerr_msg));
   pcxs_status uut (.sys_clk(sys_clk), .resetn(resetn), .cfg(cfg),
      .scerr_msg(scerr_msg), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .read_size(read_size), .irq(irq));

   // ==========================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [2:0] exp_size(input pcxs_cfg_t v);
      if (v.read_size_map_select)
         return v.large_read ? 3'h2 : 3'h1;
      return (v.byte_count == 2'h3) ? 3'h2 :
             (v.byte_count == 2'h2) ? 3'h1 : 3'h0;
   endfunction

   function automatic logic [31:0] stat(input logic f, input logic [2:0] s);
      return {2'h0, f, s, 26'h0};
   endfunction

   // both channels offered together, each dropped once taken
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s,
                     input logic [1:0] e);
      wq.push_back(e);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [31:0] a, d, input logic [1:0] e);
      rq.push_back({e, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ==========================================================
   // monitor: oldest note is compared at each handshake
   always @(posedge sys_clk) begin
      if (bvalid && bready) begin
         eb = wq.pop_front();
         `CHK("bresp", eb, bresp)
      end
      if (rvalid && rready) begin
         er = rq.pop_front();
         `CHK("rresp", er[33:32], rresp)
         `CHK("rdata", er[31:0], rdata)
      end
   end

   // watchdog sized well past the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      results;
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      rd(PCXS_STATUS_OFS, stat(1'b0, 3'h0), PCXS_RESP_OK);
      rd(PCXS_MASK_OFS, 32'h0, PCXS_RESP_OK);
      $display("test reset done");
      rnd = xs(rnd);
      k = rnd[3:0];
      // every cfg value once, in a shuffled order
      for (int i = 0; i < 16; i++) begin
         rnd = xs(rnd);
         c = pcxs_cfg_t'(i[3:0] ^ k);
         cfg_req <= c;
         repeat (3) @(posedge sys_clk);
         `CHK("read_size", exp_size(c), read_size)
         wr(PCXS_STATUS_OFS, rnd & ~ERRB, 4'hf, PCXS_RESP_OK);
         rd(PCXS_STATUS_OFS, stat(1'b0, exp_size(c)), PCXS_RESP_OK);
      end
      sz = exp_size(c);
      $display("test sweep done");
      err_req <= 1'b1;
      @(posedge sys_clk);
      err_req <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd(PCXS_STATUS_OFS, stat(1'b1, sz), PCXS_RESP_OK);
      `CHK("irq", 1'b0, irq)
      wr(PCXS_STATUS_OFS, 32'h0, 4'hf, PCXS_RESP_OK);
      rd(PCXS_STATUS_OFS, stat(1'b1, sz), PCXS_RESP_OK);
      wr(PCXS_STATUS_OFS, ERRB, 4'h7, PCXS_RESP_OK);
      rd(PCXS_STATUS_OFS, stat(1'b1, sz), PCXS_RESP_OK);
      wr(PCXS_MASK_OFS, ERRB, 4'hf, PCXS_RESP_OK);
      `CHK("irq", 1'b1, irq)
      rd(PCXS_MASK_OFS, ERRB, PCXS_RESP_OK);
      // event held through a clearing write: the set must win
      err_req <= 1'b1;
      wr(PCXS_STATUS_OFS, ERRB, 4'hf, PCXS_RESP_OK);
      err_req <= 1'b0;
      rd(PCXS_STATUS_OFS, stat(1'b1, sz), PCXS_RESP_OK);
      wr(PCXS_STATUS_OFS, ERRB, 4'hf, PCXS_RESP_OK);
      rd(PCXS_STATUS_OFS, stat(1'b0, sz), PCXS_RESP_OK);
      `CHK("irq", 1'b0, irq)
      $display("test flag done");
      wr(32'h0000_0008, rnd, 4'hf, PCXS_RESP_ERR);
      rd(32'h0000_0008, 32'h0, PCXS_RESP_ERR);
      $display("test unmapped done");
      results;
   end
endmodule
